/* rtl/spcm_params.svh */
// Offsets, field positions, reset values and limits of the positioning setup block.
// Assumes a byte-addressed 32-bit register port.
`ifndef SPCM_PARAMS_SVH
`define SPCM_PARAMS_SVH

`define SPCM_OFF_PPR 8'h00
`define SPCM_OFF_ACCEL 8'h04
`define SPCM_OFF_DECEL 8'h08
`define SPCM_OFF_DBAND 8'h0C
`define SPCM_OFF_FLAGS 8'h10
`define SPCM_OFF_POL 8'h14
`define SPCM_OFF_CHAT 8'h18
`define SPCM_OFF_STAB 8'h1C
`define SPCM_OFF_LEVEL 8'h20
`define SPCM_OFF_MON 8'h24

`define SPCM_PPR_MAX 32'h004FFFFF
`define SPCM_PPR_ZERO 23'h500000
`define SPCM_PPR_RST 23'h280000
`define SPCM_PROF_MIN 32'h00000001
`define SPCM_PROF_MAX 32'h00000005
`define SPCM_ACCEL_RST 3'h1
`define SPCM_DECEL_RST 3'h0
`define SPCM_DBAND_MAX 32'h00000FFF
`define SPCM_DBAND_RST 12'h000
`define SPCM_FLAGS_MAX 32'h00000007
`define SPCM_FLAGS_RST 3'h0
`define SPCM_POL_MAX 32'h00000007
`define SPCM_LEVEL_MAX 32'h00000003
`define SPCM_BYTE_MAX 32'h000000FF
`define SPCM_CHAT_RST 8'h04
`define SPCM_STAB_RST 8'h04

`define SPCM_FLAG_INV 0
`define SPCM_FLAG_NOTICE 1
`define SPCM_FLAG_PHASE 2
`define SPCM_MON_BUSY 3
`define SPCM_MON_RDY 4

`define SPCM_NOTICE_CHAR 8'h21

`endif

/* rtl/spcm_pkg.sv */
// Types of the positioning setup block.
// Assumes spcm_params.svh for all numeric constants.
package spcm_pkg;

    typedef enum logic [1:0] {
        NOTE_IDLE,
        NOTE_PEND,
        NOTE_SEND
    } spcm_note_state_t;

endpackage : spcm_pkg

/* rtl/spcm_core.sv */
// Servo positioning settings, control monitors and serial ready notice.
// Assumes one 100 MHz clock, synchronous inputs and a one-cycle strobe master.
//
// What this block does
// R01 - Pulse-train resolution is 0 to 5242879, zero meaning 5242880, reset 2621440.
// R02 - Acceleration curve code is 1 to 5 for internal moves, reset 1.
// R03 - Deceleration curve code is 1 to 5, and 0 (reset) follows the acceleration code.
// R04 - Velocity command is forced to zero while twice the error magnitude is within the band.
// R05 - Scale counts up on clockwise steps when not inverted, counterclockwise when inverted.
// R06 - Inversion leaves travel limits and feedback phase untouched.
// R07 - With the notice enabled an exclamation mark is sent after a move completes.
// R08 - The notice waits while the terminal is partway through an entry.
// R09 - Input monitors show inputs after polarity and chatter filter.
// R10 - Output monitors show internal state before stability timer and output level.
// R11 - Alarm clear monitor reads 1 when the input is active.
// R12 - Busy monitor reads 1 while an operation runs.
// R13 - Feedback phase order 0 has phase A leading clockwise, 1 phase B.
// R14 - Jog direction monitor reads 0 for plus and 1 for minus.
// R15 - Driver ready monitor reads 1 in normal operation, 0 with an alarm.
// R16 - Emergency stop monitor reads 1 when a stop is asserted.
// R17 - A write outside the legal range leaves the stored setting unchanged.
`timescale 1ns/1ps
`include "spcm_params.svh"

module spcm_core #(
    parameter int ERR_W = 24,
    parameter int CNT_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic alarm_clear_in,
    input wire logic jog_dir_in,
    input wire logic emergency_stop_in,
    input wire logic busy_int_i,
    input wire logic ready_int_i,
    output logic busy_o,
    output logic driver_ready_out,
    input wire logic signed [ERR_W-1:0] pos_err_i,
    input wire logic signed [ERR_W-1:0] vel_cmd_i,
    output logic signed [ERR_W-1:0] vel_cmd_o,
    output logic [22:0] pulses_per_rev_o,
    output logic [2:0] accel_profile_o,
    output logic [2:0] decel_profile_o,
    input wire logic cw_step_i,
    input wire logic ccw_step_i,
    input wire logic limit_cw_i,
    input wire logic limit_ccw_i,
    output logic limit_cw_o,
    output logic limit_ccw_o,
    output logic [31:0] pos_scale_o,
    output logic fb_a_o,
    output logic fb_b_o,
    input wire logic op_done_i,
    input wire logic entry_busy_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o
);

    function automatic logic fits(input logic [31:0] v, input logic [31:0] lo,
                                  input logic [31:0] hi);
        fits = (v >= lo) && (v <= hi);
    endfunction : fits

    // ****************************************
    // Settings registers
    // ****************************************
    logic [22:0] ppr_reg, ppr_next;
    logic [2:0] accel_reg, accel_next;
    logic [2:0] decel_reg, decel_next;
    logic [11:0] dband_reg, dband_next;
    logic [2:0] flags_reg, flags_next;
    logic [2:0] pol_reg, pol_next;
    logic [CNT_W-1:0] chat_reg, chat_next;
    logic [CNT_W-1:0] stab_reg, stab_next;
    logic [1:0] level_reg, level_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [4:0] mon_reg, mon_next;
    logic [2:0] in_filt;
    logic [1:0] out_held;

    always_comb
    begin
        ppr_next = ppr_reg;
        accel_next = accel_reg;
        decel_next = decel_reg;
        dband_next = dband_reg;
        flags_next = flags_reg;
        pol_next = pol_reg;
        chat_next = chat_reg;
        stab_next = stab_reg;
        level_next = level_reg;
        if (wr_i)
        begin
            if (addr_i == `SPCM_OFF_PPR && fits(wdata_i, 32'h0, `SPCM_PPR_MAX)) // R01 R17
                ppr_next = wdata_i[22:0];
            else if (addr_i == `SPCM_OFF_ACCEL
                     && fits(wdata_i, `SPCM_PROF_MIN, `SPCM_PROF_MAX)) // R02 R17
                accel_next = wdata_i[2:0];
            else if (addr_i == `SPCM_OFF_DECEL
                     && fits(wdata_i, 32'h0, `SPCM_PROF_MAX)) // R03 R17
                decel_next = wdata_i[2:0];
            else if (addr_i == `SPCM_OFF_DBAND
                     && fits(wdata_i, 32'h0, `SPCM_DBAND_MAX)) // R04 R17
                dband_next = wdata_i[11:0];
            else if (addr_i == `SPCM_OFF_FLAGS
                     && fits(wdata_i, 32'h0, `SPCM_FLAGS_MAX)) // R17
                flags_next = wdata_i[2:0];
            else if (addr_i == `SPCM_OFF_POL && fits(wdata_i, 32'h0, `SPCM_POL_MAX))
                pol_next = wdata_i[2:0];
            else if (addr_i == `SPCM_OFF_CHAT && fits(wdata_i, 32'h0, `SPCM_BYTE_MAX))
                chat_next = wdata_i[CNT_W-1:0];
            else if (addr_i == `SPCM_OFF_STAB && fits(wdata_i, 32'h0, `SPCM_BYTE_MAX))
                stab_next = wdata_i[CNT_W-1:0];
            else if (addr_i == `SPCM_OFF_LEVEL
                     && fits(wdata_i, 32'h0, `SPCM_LEVEL_MAX))
                level_next = wdata_i[1:0];
        end
        rdata_next = 32'h0;
        if (rd_i)
        begin
            if (addr_i == `SPCM_OFF_PPR)
                rdata_next = {9'h0, ppr_reg};
            else if (addr_i == `SPCM_OFF_ACCEL)
                rdata_next = {29'h0, accel_reg};
            else if (addr_i == `SPCM_OFF_DECEL)
                rdata_next = {29'h0, decel_reg};
            else if (addr_i == `SPCM_OFF_DBAND)
                rdata_next = {20'h0, dband_reg};
            else if (addr_i == `SPCM_OFF_FLAGS)
                rdata_next = {29'h0, flags_reg};
            else if (addr_i == `SPCM_OFF_POL)
                rdata_next = {29'h0, pol_reg};
            else if (addr_i == `SPCM_OFF_CHAT)
                rdata_next = {{(32-CNT_W){1'b0}}, chat_reg};
            else if (addr_i == `SPCM_OFF_STAB)
                rdata_next = {{(32-CNT_W){1'b0}}, stab_reg};
            else if (addr_i == `SPCM_OFF_LEVEL)
                rdata_next = {30'h0, level_reg};
            else if (addr_i == `SPCM_OFF_MON)
                rdata_next = {27'h0, mon_reg};
        end
        // Filtered inputs and raw internal outputs
        mon_next = {ready_int_i, busy_int_i, in_filt}; // R09 R10 R11 R12 R14 R15 R16
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ppr_reg <= `SPCM_PPR_RST;
            accel_reg <= `SPCM_ACCEL_RST;
            decel_reg <= `SPCM_DECEL_RST;
            dband_reg <= `SPCM_DBAND_RST;
            flags_reg <= `SPCM_FLAGS_RST;
            pol_reg <= 3'h0;
            chat_reg <= `SPCM_CHAT_RST;
            stab_reg <= `SPCM_STAB_RST;
            level_reg <= 2'h0;
            rdata_reg <= 32'h0;
            mon_reg <= 5'h0;
        end
        else
        begin
            ppr_reg <= ppr_next;
            accel_reg <= accel_next;
            decel_reg <= decel_next;
            dband_reg <= dband_next;
            flags_reg <= flags_next;
            pol_reg <= pol_next;
            chat_reg <= chat_next;
            stab_reg <= stab_next;
            level_reg <= level_next;
            rdata_reg <= rdata_next;
            mon_reg <= mon_next;
        end
    end

    assign rdata_o = rdata_reg;

    // ****************************************
    // Input polarity and chatter filter
    // ****************************************
    logic [2:0] in_raw;
    assign in_raw = {emergency_stop_in, jog_dir_in, alarm_clear_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_in
            logic filt_reg, filt_next;
            logic [CNT_W-1:0] cnt_reg, cnt_next;
            always_comb
            begin
                filt_next = filt_reg;
                cnt_next = '0;
                if ((in_raw[gi] ^ pol_reg[gi]) != filt_reg) // R09
                begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg >= chat_reg)
                    begin
                        filt_next = ~filt_reg;
                        cnt_next = '0;
                    end
                end
            end
            always_ff @(posedge clk_sys_i)
            begin
                if (sys_rst_i)
                begin
                    filt_reg <= 1'b0;
                    cnt_reg <= '0;
                end
                else
                begin
                    filt_reg <= filt_next;
                    cnt_reg <= cnt_next;
                end
            end
            assign in_filt[gi] = filt_reg;
        end

        // ****************************************
        // Output stability timer and logic level
        // ****************************************
        for (gi = 0; gi < 2; gi++)
        begin : g_out
            logic held_reg, held_next;
            logic [CNT_W-1:0] cnt_reg, cnt_next;
            logic src;
            assign src = (gi == 0) ? busy_int_i : ready_int_i;
            always_comb
            begin
                held_next = held_reg;
                cnt_next = '0;
                if (src != held_reg)
                begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg >= stab_reg)
                    begin
                        held_next = src;
                        cnt_next = '0;
                    end
                end
            end
            always_ff @(posedge clk_sys_i)
            begin
                if (sys_rst_i)
                begin
                    held_reg <= 1'b0;
                    cnt_reg <= '0;
                end
                else
                begin
                    held_reg <= held_next;
                    cnt_reg <= cnt_next;
                end
            end
            assign out_held[gi] = held_reg ^ level_reg[gi];
        end
    endgenerate

    assign busy_o = out_held[0];
    assign driver_ready_out = out_held[1];

    // ****************************************
    // Motion setting outputs
    // ****************************************
    logic [22:0] ppr_eff_reg, ppr_eff_next;
    logic [2:0] acc_o_reg, acc_o_next, dec_o_reg, dec_o_next;
    logic signed [ERR_W-1:0] vel_reg, vel_next;
    logic [31:0] scale_reg, scale_next;
    logic [1:0] quad_reg, quad_next;
    logic [ERR_W-1:0] err_mag;
    logic lim_cw_reg, lim_ccw_reg;

    always_comb
    begin
        ppr_eff_next = (ppr_reg == 23'h0) ? `SPCM_PPR_ZERO : ppr_reg; // R01
        acc_o_next = accel_reg; // R02
        dec_o_next = (decel_reg == 3'h0) ? accel_reg : decel_reg; // R03
        err_mag = pos_err_i[ERR_W-1] ? ERR_W'(-pos_err_i) : ERR_W'(pos_err_i);
        if ({1'b0, err_mag, 1'b0} <= {{(ERR_W-10){1'b0}}, dband_reg}) // R04
            vel_next = '0;
        else
            vel_next = vel_cmd_i;
        scale_next = scale_reg;
        if (cw_step_i && !ccw_step_i)
            scale_next = flags_reg[`SPCM_FLAG_INV] ? scale_reg - 1'b1 : scale_reg + 1'b1; // R05
        else if (ccw_step_i && !cw_step_i)
            scale_next = flags_reg[`SPCM_FLAG_INV] ? scale_reg + 1'b1 : scale_reg - 1'b1; // R05
        // Feedback sequence ignores inversion
        quad_next = quad_reg; // R06
        if (cw_step_i && !ccw_step_i)
            quad_next = quad_reg + 2'h1;
        else if (ccw_step_i && !cw_step_i)
            quad_next = quad_reg - 2'h1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ppr_eff_reg <= `SPCM_PPR_RST;
            acc_o_reg <= `SPCM_ACCEL_RST;
            dec_o_reg <= `SPCM_ACCEL_RST;
            vel_reg <= '0;
            scale_reg <= 32'h0;
            quad_reg <= 2'h0;
            lim_cw_reg <= 1'b0;
            lim_ccw_reg <= 1'b0;
        end
        else
        begin
            ppr_eff_reg <= ppr_eff_next;
            acc_o_reg <= acc_o_next;
            dec_o_reg <= dec_o_next;
            vel_reg <= vel_next;
            scale_reg <= scale_next;
            quad_reg <= quad_next;
            lim_cw_reg <= limit_cw_i; // R06
            lim_ccw_reg <= limit_ccw_i; // R06
        end
    end

    // Gray step: A = bit1 ^ bit0, B = bit1, so A leads on count up
    logic qa, qb;
    assign qa = quad_reg[1] ^ quad_reg[0];
    assign qb = quad_reg[1];
    assign fb_a_o = flags_reg[`SPCM_FLAG_PHASE] ? qb : qa; // R13
    assign fb_b_o = flags_reg[`SPCM_FLAG_PHASE] ? qa : qb; // R13
    assign pulses_per_rev_o = ppr_eff_reg;
    assign accel_profile_o = acc_o_reg;
    assign decel_profile_o = dec_o_reg;
    assign vel_cmd_o = vel_reg;
    assign pos_scale_o = scale_reg;
    assign limit_cw_o = lim_cw_reg;
    assign limit_ccw_o = lim_ccw_reg;

    // ****************************************
    // Ready notice
    // ****************************************
    spcm_pkg::spcm_note_state_t note_reg, note_next;

    always_comb
    begin
        note_next = note_reg;
        case (note_reg)
            spcm_pkg::NOTE_IDLE:
                if (op_done_i && flags_reg[`SPCM_FLAG_NOTICE]) // R07
                    note_next = spcm_pkg::NOTE_PEND;
            spcm_pkg::NOTE_PEND:
                if (!entry_busy_i) // R08
                    note_next = spcm_pkg::NOTE_SEND;
            spcm_pkg::NOTE_SEND:
                if (tx_ready_i)
                    note_next = spcm_pkg::NOTE_IDLE;
            default:
                note_next = spcm_pkg::NOTE_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            note_reg <= spcm_pkg::NOTE_IDLE;
        else
            note_reg <= note_next;
    end

    assign tx_valid_o = (note_reg == spcm_pkg::NOTE_SEND); // R07
    assign tx_data_o = `SPCM_NOTICE_CHAR;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_ppr_zero;
        ppr_reg == 23'h0 |=> pulses_per_rev_o == `SPCM_PPR_ZERO;
    endproperty
    a_ppr_zero: assert property (p_ppr_zero) else $error("zero resolution not mapped"); // R01
    property p_decel_follow;
        decel_reg == 3'h0 |=> decel_profile_o == $past(accel_reg);
    endproperty
    a_decel_follow: assert property (p_decel_follow) else $error("decel not following"); // R03
    property p_dead_band;
        ({1'b0, err_mag, 1'b0} <= {{(ERR_W-10){1'b0}}, dband_reg}) |=> vel_cmd_o == '0;
    endproperty
    a_dead_band: assert property (p_dead_band) else $error("velocity not zeroed"); // R04
    property p_scale_up;
        cw_step_i && !ccw_step_i && !flags_reg[`SPCM_FLAG_INV]
            |=> pos_scale_o == $past(pos_scale_o) + 32'h1;
    endproperty
    a_scale_up: assert property (p_scale_up) else $error("scale not counting up"); // R05
    property p_notice_start;
        note_reg == spcm_pkg::NOTE_IDLE && op_done_i && flags_reg[`SPCM_FLAG_NOTICE]
            ##1 !entry_busy_i |=> tx_valid_o && tx_data_o == `SPCM_NOTICE_CHAR;
    endproperty
    a_notice_start: assert property (p_notice_start) else $error("notice not sent"); // R07
    property p_notice_hold;
        note_reg == spcm_pkg::NOTE_PEND && entry_busy_i |=> !tx_valid_o;
    endproperty
    a_notice_hold: assert property (p_notice_hold) else $error("notice sent mid entry"); // R08
    property p_busy_mon;
        busy_int_i ##1 busy_int_i |=> mon_reg[`SPCM_MON_BUSY];
    endproperty
    a_busy_mon: assert property (p_busy_mon) else $error("busy monitor wrong"); // R12
    property p_reject;
        wr_i && addr_i == `SPCM_OFF_ACCEL && !fits(wdata_i, `SPCM_PROF_MIN, `SPCM_PROF_MAX)
            |=> accel_reg == $past(accel_reg);
    endproperty
    a_reject: assert property (p_reject) else $error("illegal accel code stored"); // R17

    c_notice: cover property (note_reg == spcm_pkg::NOTE_SEND && tx_ready_i);
    c_held: cover property (note_reg == spcm_pkg::NOTE_PEND && entry_busy_i);
    c_band: cover property (dband_reg != 12'h0 && vel_cmd_i != '0 ##1 vel_cmd_o == '0);
    c_reject: cover property (wr_i && addr_i == `SPCM_OFF_PPR && wdata_i > `SPCM_PPR_MAX);

endmodule : spcm_core

/* bench/spcm_term_model.sv */
// Serial terminal model: takes notice bytes and flags an entry in progress.
// Assumes the core's one-byte valid/ready handshake on the system clock.
`timescale 1ns/1ps

module spcm_term_model (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic [3:0] stall_i,
    input wire logic entry_i,
    output logic ready_o,
    output logic entry_busy_o,
    output int rx_cnt_o,
    output logic [7:0] rx_byte_o
);
    int wait_cnt;

    // ********************************
    // Ready after a chosen stall
    // ********************************
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ready_o <= 1'b0;
            entry_busy_o <= 1'b0;
            wait_cnt <= 0;
            rx_cnt_o <= 0;
            rx_byte_o <= 8'h00;
        end
        else
        begin
            entry_busy_o <= entry_i;
            ready_o <= 1'b0;
            if (valid_i && ready_o)
            begin
                rx_cnt_o <= rx_cnt_o + 1;
                rx_byte_o <= data_i;
            end
            else if (valid_i && wait_cnt >= int'(stall_i))
            begin
                ready_o <= 1'b1;
                wait_cnt <= 0;
            end
            else if (valid_i)
                wait_cnt <= wait_cnt + 1;
        end
    end
endmodule : spcm_term_model

/* bench/spcm_core_tb.sv */
// Self-checking bench of the positioning setup core.
// Assumes spcm_params.svh on the include path and the terminal model beside it.
`timescale 1ns/1ps
`include "spcm_params.svh"

module spcm_core_tb;
    logic clk_sys_i, sys_rst_i, wr_i, rd_i, busy_o, driver_ready_out;
    logic [7:0] addr_i, tx_data_o, rx_byte;
    logic [31:0] wdata_i, rdata_o, pos_scale_o;
    logic alarm_clear_in, jog_dir_in, emergency_stop_in, busy_int_i, ready_int_i;
    logic cw_step_i, ccw_step_i, limit_cw_i, limit_ccw_i, limit_cw_o, limit_ccw_o;
    logic fb_a_o, fb_b_o, op_done_i, entry_busy_i, tx_ready_i, tx_valid_o, entry_req;
    logic [3:0] stall;
    logic signed [23:0] pos_err_i, vel_cmd_i, vel_cmd_o;
    logic [22:0] pulses_per_rev_o;
    logic [2:0] accel_profile_o, decel_profile_o;
    int miscompares, tests_run, rx_cnt, cycles, scale, fbc;
    int unsigned m [10];
    int unsigned hi [9] = '{32'h4FFFFF, 32'h5, 32'h5, 32'hFFF, 32'h7, 32'h7, 32'hFF, 32'hFF, 32'h3};
    int unsigned lo [9] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [39:0] tbl [17] = '{40'h00_00000000, 40'h00_004FFFFF, 40'h00_00500000,
        40'h00_FFFFFFFF, 40'h04_00000000, 40'h04_00000006, 40'h08_00000006,
        40'h0C_00000FFF, 40'h0C_00001000, 40'h10_00000008, 40'h14_00000008,
        40'h18_00000100, 40'h1C_00000100, 40'h20_00000004, 40'h24_000000FF,
        40'h28_00000001, 40'h02_00000001};

    spcm_core dut_u (.clk_sys_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .alarm_clear_in, .jog_dir_in, .emergency_stop_in, .busy_int_i, .ready_int_i,
        .busy_o, .driver_ready_out, .pos_err_i, .vel_cmd_i, .vel_cmd_o, .pulses_per_rev_o,
        .accel_profile_o, .decel_profile_o, .cw_step_i, .ccw_step_i, .limit_cw_i,
        .limit_ccw_i, .limit_cw_o, .limit_ccw_o, .pos_scale_o, .fb_a_o, .fb_b_o,
        .op_done_i, .entry_busy_i, .tx_ready_i, .tx_valid_o, .tx_data_o);

    spcm_term_model term_u (.clk_sys_i, .sys_rst_i, .valid_i(tx_valid_o),
        .data_i(tx_data_o), .stall_i(stall), .entry_i(entry_req), .ready_o(tx_ready_i),
        .entry_busy_o(entry_busy_i), .rx_cnt_o(rx_cnt), .rx_byte_o(rx_byte));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // ****************
    // Bus and checks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        i = a >> 2;
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        if (a[1:0] == 2'h0 && i < 9 && d >= lo[i] && d <= hi[i])
            m[i] = d;
    endtask : wr

    function automatic logic [31:0] exp_reg(input logic [7:0] a);
        logic [4:0] mon;
        mon = {ready_int_i, busy_int_i,
            {emergency_stop_in, jog_dir_in, alarm_clear_in} ^ m[5][2:0]};
        if (a == 8'h24)
            return {27'h0, mon};
        if (a[1:0] != 2'h0 || a > 8'h20)
            return 32'h0;
        return m[a >> 2];
    endfunction : exp_reg

    task automatic rdchk(input logic [7:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp_reg(a));
    endtask : rdchk

    task automatic outs_chk;
        chk(pulses_per_rev_o, m[0] == 0 ? 32'h500000 : m[0]);
        chk(accel_profile_o, m[1]);
        chk(decel_profile_o, m[2] == 0 ? m[1] : m[2]);
    endtask : outs_chk

    task automatic finish_test;
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        int k, b, e, v, s, c, ae, w;
        int unsigned r;
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        scale = 0;
        fbc = 0;
        m = '{32'h280000, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h4, 32'h0, 32'h0};
        sys_rst_i = 1'b1;
        {wr_i, rd_i, addr_i, wdata_i, alarm_clear_in, jog_dir_in, emergency_stop_in} = '0;
        {busy_int_i, ready_int_i, pos_err_i, vel_cmd_i, cw_step_i, ccw_step_i} = '0;
        {limit_cw_i, limit_ccw_i, op_done_i, entry_req, stall} = '0;
        r = $urandom(40510);
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        for (k = 0; k <= 40; k += 4)
            rdchk(8'(k));
        outs_chk();
        chk(pos_scale_o, 32'h0);
        foreach (tbl[i])
        begin
            wr(tbl[i][39:32], tbl[i][31:0]);
            rdchk(tbl[i][39:32] & 8'hFC);
            outs_chk();
        end
        for (k = 0; k < 49; k++)
        begin
            wr(8'h04, k / 7);
            wr(8'h08, k % 7);
            rdchk(8'h08);
            outs_chk();
        end
        for (k = 0; k < 40; k++)
        begin
            // Monitor left out: filter may still be settling
            r = ($urandom % 10) * 4;
            r = (r == 36) ? 40 : r;
            wr(8'(r), $urandom >> ($urandom % 32));
            rdchk(8'(r));
            outs_chk();
        end
        for (k = 0; k < 16; k++)
        begin
            if (k % 4 == 0)
                wr(8'h0C, $urandom % 4096);
            b = m[3];
            e = b / 2 + k % 3 - 1;
            e = k[0] ? -e : e;
            ae = e < 0 ? -e : e;
            v = $urandom;
            @(posedge clk_sys_i);
            pos_err_i <= 24'(e);
            vel_cmd_i <= 24'(v);
            @(posedge clk_sys_i);
            #1 chk(vel_cmd_o, (2 * ae <= b) ? 24'sh0 : 24'(v));
        end
        for (k = 0; k < 32; k++)
        begin
            if (k % 8 == 0)
                wr(8'h10, {29'h0, k[4], 1'b0, k[3]});
            s = $urandom % 4;
            r = $urandom % 4;
            @(posedge clk_sys_i);
            {ccw_step_i, cw_step_i} <= s[1:0];
            {limit_ccw_i, limit_cw_i} <= r[1:0];
            @(posedge clk_sys_i);
            {ccw_step_i, cw_step_i} <= 2'h0;
            w = (s == 1) ? 1 : (s == 2) ? -1 : 0;
            scale += m[4][0] ? -w : w;
            fbc = (fbc + w) & 3;
            #1 chk(pos_scale_o, scale);
            chk({fb_a_o, fb_b_o}, m[4][2] ? {fbc[1], fbc[1] ^ fbc[0]}
                : {fbc[1] ^ fbc[0], fbc[1]});
            chk({limit_ccw_o, limit_cw_o}, r[1:0]);
        end
        wr(8'h18, 32'h2);
        wr(8'h1C, 32'h1);
        for (k = 0; k < 8; k++)
        begin
            r = $urandom;
            wr(8'h14, r % 8);
            wr(8'h20, (r >> 3) % 4);
            {alarm_clear_in, jog_dir_in, emergency_stop_in, busy_int_i, ready_int_i} <= r[9:5];
            repeat (8) @(posedge clk_sys_i);
            rdchk(8'h24);
            chk({busy_o, driver_ready_out}, {busy_int_i ^ m[8][0], ready_int_i ^ m[8][1]});
        end
        @(posedge clk_sys_i);
        alarm_clear_in <= ~alarm_clear_in;
        repeat (2) @(posedge clk_sys_i);
        alarm_clear_in <= ~alarm_clear_in;
        repeat (6) @(posedge clk_sys_i);
        rdchk(8'h24);
        for (k = 0; k < 4; k++)
        begin
            stall <= 4'($urandom % 6);
            entry_req <= (k != 3);
            wr(8'h10, (k == 2) ? 32'h0 : 32'h2);
            c = rx_cnt;
            op_done_i <= 1'b1;
            @(posedge clk_sys_i);
            op_done_i <= 1'b0;
            repeat (10) @(posedge clk_sys_i);
            #1 chk(tx_valid_o, 1'b0);
            chk(rx_cnt - c, (k == 3) ? 32'h1 : 32'h0);
            @(posedge clk_sys_i);
            entry_req <= 1'b0;
            for (w = 0; w < 40 && rx_cnt == c; w++)
                @(posedge clk_sys_i);
            chk(rx_cnt - c, (k == 2) ? 32'h0 : 32'h1);
            chk(rx_byte, 8'h21);
        end
        finish_test();
    end
endmodule : spcm_core_tb
